/* File: hdl/cemb_memory_block.sv */
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
// Operation
// - Memory organises as 128x16, 256x8, 512x4, 1024x2 or 2048x1.
// - Write address, data and enable are registered; read output register is optional.
// - A read and a write may proceed together, each on its own port.
// - The block makes its own write strobe from the clock.
// - Wider memories are blocks side by side sharing address and control.
// - Deep memories share a line; a page decoder enables this block's driver.
// - Eleven low address bits feed the array, two upper bits the page decoder.
// - Exactly one block drives the shared line in memory mode; in reset and product-term mode this block's driver is off.
// - Each block selects memory mode or product-term mode.
// - Product-term mode gives 16 macrocells, two terms and a register each.
// - The array takes 32 routing inputs plus nine macrocell feedbacks.
// - Each macrocell output is registered or combinational by choice.
// - Each term feeds its own OR/XOR or expands into the next macrocell; macrocell 15 has no next one to expand into.
// - One term per macrocell may be inverted for wide OR functions.
// - Write port registers follow the write clock, read ones the read clock.
// - Read and write sides have own enables and clears; reset clears everything.
module cemb_memory_block
   import cemb_pkg::*;
(
   input  wire logic                           clk,
   input  wire logic                           rst_n,
   input  wire logic                           ce,
   input  wire cemb_mode_t                     mode,
   input  wire cemb_width_t                    widthCfg,
   input  wire logic                           outRegEn,
   input  wire logic                           wrClkEn,
   input  wire logic                           wrClear_n,
   input  wire cemb_wr_t                       wrPort,
   input  wire logic                           rdClkEn,
   input  wire logic                           rdClear_n,
   input  wire cemb_rd_t                       rdPort,
   input  wire logic                           pageEn,
   input  wire logic [CEMB_PAGE_W-1:0]         pageSel,
   input  wire logic                           ptClkEn,
   input  wire logic                           ptClear_n,
   input  wire logic [CEMB_PT_IN-1:0]          ptIn,
   input  wire cemb_mc_cfg_t [CEMB_MC_NUM-1:0] mcCfg,
   output logic      [CEMB_DATA_W-1:0]         dataOut,
   output logic      [CEMB_DATA_W-1:0]         lineOut,
   output logic                                lineOe
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   cemb_wr_t                 wrReg_r;
   logic                     wrPulse_r;
   cemb_rd_t                 rdReg_r;
   cemb_rd_t                 rdReg_nxt;
   logic [CEMB_DATA_W-1:0]   dataOut_r;
   logic                     lineOe_r;
   logic                     lineOe_nxt;
   logic                     memMode;
   logic [CEMB_ADDR_W-1:0]   wrPos;
   logic [CEMB_ADDR_W-1:0]   rdPos;
   logic [CEMB_DATA_W-1:0]   laneMask;
   logic [CEMB_DATA_W-1:0]   rowWord;
   logic [CEMB_DATA_W-1:0]   readWord;
   logic [CEMB_DATA_W-1:0]   memData;
   logic [CEMB_MC_NUM-1:0]   mcOut;

   assign memMode  = (mode == CEMB_MEM_MODE);
   assign laneMask = cemb_lane_mask(widthCfg);

   // ------------------------------------------------------------
   // Write port
   // ------------------------------------------------------------
   // Each write clock enable stands for one edge of the write clock, so the
   // write side keeps its own cadence independent of the read side.
   always_ff @(posedge clk) begin
      if (!rst_n || !wrClear_n) begin
         wrReg_r <= '0;
      end else if (ce && wrClkEn) begin
         wrReg_r <= wrPort;
      end
   end

   // The strobe is a single cycle after capture, so the surrounding logic
   // never has to shape a write pulse around setup and hold.
   always_ff @(posedge clk) begin
      if (!rst_n || !wrClear_n) begin
         wrPulse_r <= 1'b0;
      end else if (ce) begin
         wrPulse_r <= wrClkEn && wrPort.we && memMode;
      end
   end

   assign wrPos = cemb_bit_pos(wrReg_r.addr, widthCfg);
   assign rdPos = cemb_bit_pos(rdReg_r.addr[CEMB_ADDR_W-1:0], widthCfg);

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   cemb_storage #(
      .ROWS  (CEMB_ROWS),
      .WIDTH (CEMB_DATA_W)
   ) uStorage (
      .clk    (clk),
      .rst_n  (rst_n),
      .wrEn   (ce && wrPulse_r),
      .wrRow  (wrPos[CEMB_ADDR_W-1:CEMB_LANE_W]),
      .wrMask (laneMask << wrPos[CEMB_LANE_W-1:0]),
      .wrData ((wrReg_r.data & laneMask) << wrPos[CEMB_LANE_W-1:0]),
      .rdRow  (rdPos[CEMB_ADDR_W-1:CEMB_LANE_W]),
      .rdWord (rowWord)
   );

   // Narrow organisations return the word in the low bits, the rest zero.
   assign readWord = (rowWord >> rdPos[CEMB_LANE_W-1:0]) & laneMask;

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   always_comb begin
      rdReg_nxt = rdReg_r;
      if (!rdClear_n) begin
         rdReg_nxt = '0;
      end else if (ce && rdClkEn) begin
         rdReg_nxt = rdPort;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdReg_r <= '0;
      end else begin
         rdReg_r <= rdReg_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || !rdClear_n) begin
         dataOut_r <= CEMB_DATA_RST;
      end else if (ce && rdClkEn && rdReg_r.re) begin
         dataOut_r <= readWord;
      end
   end

   // The bypass path trades a shorter latency for a longer combinational path.
   assign memData = outRegEn ? dataOut_r : readWord;

   // ------------------------------------------------------------
   // Page decoder for the shared line
   // ------------------------------------------------------------
   // Pages of the blocks on one line are distinct, so one decoder matches for
   // every address; a block without paging drives its own line whenever it is in memory mode.
   always_comb begin
      lineOe_nxt = memMode &&
                   (!pageEn || (rdReg_nxt.addr[CEMB_PAGE_HI:CEMB_PAGE_LO] == pageSel));
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lineOe_r <= 1'b0;
      end else if (ce) begin
         lineOe_r <= lineOe_nxt;
      end
   end

   // ------------------------------------------------------------
   // Product-term mode
   // ------------------------------------------------------------
   cemb_pterm_array uPterm (
      .clk     (clk),
      .rst_n   (rst_n),
      .ce      (ce),
      .enable  (!memMode),
      .clkEn   (ptClkEn),
      .clear_n (ptClear_n),
      .ptIn    (ptIn),
      .mcCfg   (mcCfg),
      .mcOut   (mcOut)
   );

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Width expansion needs nothing here: blocks share address and control
   // and each supplies its own slice of the data.
   assign dataOut = memMode ? memData : mcOut;
   assign lineOut = memData;
   assign lineOe  = lineOe_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cbMem @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence sWrCapture;
      ce && wrClkEn && wrPort.we && memMode && wrClear_n;
   endsequence

   sequence sRdCapture;
      ce && rdClkEn && rdPort.re && rdClear_n;
   endsequence

   AST_WR_REGISTERED: assert property (
      (ce && wrClkEn && wrClear_n) |=> (wrReg_r == $past(wrPort)))
      else $error("Write port registers did not capture the write inputs.");

   AST_WR_STROBE: assert property (
      sWrCapture |=> wrPulse_r ##1 (!wrPulse_r || $past(wrClkEn && wrPort.we)))
      else $error("Internal write strobe missing or longer than one cycle.");

   AST_DUAL_PORT: assert property (
      (sWrCapture and sRdCapture) |=> (wrPulse_r && rdReg_r.re))
      else $error("Simultaneous read and write were not both accepted.");

   AST_RD_FROZEN: assert property (
      (!rdClkEn && rdClear_n) |=> $stable(rdReg_r))
      else $error("Read registers moved without a read clock enable.");

   AST_WR_CLEAR: assert property (
      !wrClear_n |=> (wrReg_r == '0) && !wrPulse_r)
      else $error("Write side clear did not empty the write registers.");

   AST_PTERM_NO_WRITE: assert property (
      (ce && !memMode) |=> !wrPulse_r)
      else $error("Write strobe raised while in product-term mode.");

   AST_NARROW_WORD: assert property (
      memMode |-> ((readWord & ~laneMask) == '0))
      else $error("Read word carries bits beyond the configured width.");

   AST_OUT_LATENCY: assert property (
      (ce && rdClkEn && rdClear_n && rdReg_r.re && memMode && outRegEn && $stable(outRegEn))
      |=> (dataOut == $past(readWord)) || !memMode || !outRegEn)
      else $error("Registered read data did not follow the address by one cycle.");

   AST_PAGE_MISS: assert property (
      ($past(ce) && memMode && $stable(mode) && pageEn && $stable(pageEn) && $stable(pageSel)
       && (rdReg_r.addr[CEMB_PAGE_HI:CEMB_PAGE_LO] != pageSel)) |-> !lineOe)
      else $error("Shared line driven although its page is not addressed.");

   // The enable flop is cleared by reset, so the first edge after release is left out.
   AST_SOLE_DRIVER: assert property (
      ($past(ce) && $past(rst_n) && memMode && $stable(mode) && !pageEn && $stable(pageEn))
      |-> lineOe)
      else $error("Unpaged block left its shared line undriven.");

endmodule // cemb_memory_block

/* File: hdl/cemb_pkg.sv */
package cemb_pkg;

   // ------------------------------------------------------------
   // Geometry of one block
   // ------------------------------------------------------------
   localparam int CEMB_ADDR_W  = 11;
   localparam int CEMB_PAGE_W  = 2;
   localparam int CEMB_RADDR_W = CEMB_ADDR_W + CEMB_PAGE_W;
   localparam int CEMB_DATA_W  = 16;
   localparam int CEMB_ROWS    = 128;
   localparam int CEMB_ROW_W   = 7;
   localparam int CEMB_LANE_W  = 4;
   localparam int CEMB_PAGE_LO = CEMB_ADDR_W;
   localparam int CEMB_PAGE_HI = CEMB_RADDR_W - 1;

   // ------------------------------------------------------------
   // Product-term array
   // ------------------------------------------------------------
   localparam int CEMB_MC_NUM  = 16;
   localparam int CEMB_PT_IN   = 32;
   localparam int CEMB_FB_NUM  = 9;
   localparam int CEMB_ARR_IN  = CEMB_PT_IN + CEMB_FB_NUM;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [CEMB_DATA_W-1:0] CEMB_DATA_RST = 16'h0000;
   localparam logic [CEMB_MC_NUM-1:0] CEMB_MC_RST   = 16'h0000;

   typedef enum logic {CEMB_MEM_MODE, CEMB_PTERM_MODE} cemb_mode_t;

   typedef enum logic [2:0] {
      CEMB_W16,
      CEMB_W8,
      CEMB_W4,
      CEMB_W2,
      CEMB_W1
   } cemb_width_t;

   typedef struct packed {
      logic [CEMB_ADDR_W-1:0] addr;
      logic [CEMB_DATA_W-1:0] data;
      logic                   we;
   } cemb_wr_t;

   typedef struct packed {
      logic [CEMB_RADDR_W-1:0] addr;
      logic                    re;
   } cemb_rd_t;

   typedef struct packed {
      logic [CEMB_ARR_IN-1:0] use0;
      logic [CEMB_ARR_IN-1:0] use1;
      logic [CEMB_ARR_IN-1:0] cpl0;
      logic [CEMB_ARR_IN-1:0] cpl1;
      logic                   inv0;
      logic                   exp0;
      logic                   exp1;
      logic                   xorPol;
      logic                   regOut;
   } cemb_mc_cfg_t;

   // Bit position of a word in the 2048-bit array for a given organisation.
   function automatic logic [CEMB_ADDR_W-1:0] cemb_bit_pos(
      input logic [CEMB_ADDR_W-1:0] addr,
      input cemb_width_t            cfg);
      logic [CEMB_ADDR_W-1:0] pos;
      case (cfg)
         CEMB_W16: pos = {addr[6:0], 4'h0};
         CEMB_W8:  pos = {addr[7:0], 3'h0};
         CEMB_W4:  pos = {addr[8:0], 2'h0};
         CEMB_W2:  pos = {addr[9:0], 1'h0};
         default:  pos = addr;
      endcase
      return pos;
   endfunction

   function automatic logic [CEMB_DATA_W-1:0] cemb_lane_mask(input cemb_width_t cfg);
      logic [CEMB_DATA_W-1:0] m;
      case (cfg)
         CEMB_W16: m = 16'hFFFF;
         CEMB_W8:  m = 16'h00FF;
         CEMB_W4:  m = 16'h000F;
         CEMB_W2:  m = 16'h0003;
         default:  m = 16'h0001;
      endcase
      return m;
   endfunction

endpackage

/* File: hdl/cemb_pterm_array.sv */
`timescale 1ns/1ns
module cemb_pterm_array
   import cemb_pkg::*;
(
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic                          ce,
   input  wire logic                          enable,
   input  wire logic                          clkEn,
   input  wire logic                          clear_n,
   input  wire logic [CEMB_PT_IN-1:0]         ptIn,
   input  wire cemb_mc_cfg_t [CEMB_MC_NUM-1:0] mcCfg,
   output logic      [CEMB_MC_NUM-1:0]        mcOut
);

   logic [CEMB_MC_NUM-1:0] mcReg_r;
   logic [CEMB_ARR_IN-1:0] arrIn;
   logic [CEMB_MC_NUM-1:0] term0;
   logic [CEMB_MC_NUM-1:0] term1;
   logic [CEMB_MC_NUM-1:0] expand;
   logic [CEMB_MC_NUM-1:0] mcComb;

   function automatic logic pterm(
      input logic [CEMB_ARR_IN-1:0] in,
      input logic [CEMB_ARR_IN-1:0] useMask,
      input logic [CEMB_ARR_IN-1:0] cpl);
      return &((in ^ cpl) | ~useMask);
   endfunction

   // Feedback is taken from the registers so no combinational loop can form.
   assign arrIn = {mcReg_r[CEMB_FB_NUM-1:0], ptIn};

   always_comb begin
      for (int i = 0; i < CEMB_MC_NUM; i++) begin
         term0[i]  = pterm(arrIn, mcCfg[i].use0, mcCfg[i].cpl0) ^ mcCfg[i].inv0;
         term1[i]  = pterm(arrIn, mcCfg[i].use1, mcCfg[i].cpl1);
         expand[i] = (mcCfg[i].exp0 & term0[i]) | (mcCfg[i].exp1 & term1[i]);
      end
      for (int i = 0; i < CEMB_MC_NUM; i++) begin
         mcComb[i] = ((~mcCfg[i].exp0 & term0[i]) | (~mcCfg[i].exp1 & term1[i])
                     | ((i > 0) ? expand[(i + CEMB_MC_NUM - 1) % CEMB_MC_NUM] : 1'b0))
                     ^ mcCfg[i].xorPol;
         mcOut[i]  = mcCfg[i].regOut ? mcReg_r[i] : mcComb[i];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || !clear_n) begin
         mcReg_r <= CEMB_MC_RST;
      end else if (ce && clkEn && enable) begin
         mcReg_r <= mcComb;
      end
   end

   default clocking cbPt @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_MC_REGISTER: assert property (
      (ce && clkEn && enable && clear_n) |=> (mcReg_r == $past(mcComb)))
      else $error("Macrocell register did not load its product-term sum.");

endmodule // cemb_pterm_array

/* File: hdl/cemb_storage.sv */
`timescale 1ns/1ns
module cemb_storage
   import cemb_pkg::*;
#(
   parameter int ROWS  = CEMB_ROWS,
   parameter int WIDTH = CEMB_DATA_W
) (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     wrEn,
   input  wire logic [$clog2(ROWS)-1:0]  wrRow,
   input  wire logic [WIDTH-1:0]         wrMask,
   input  wire logic [WIDTH-1:0]         wrData,
   input  wire logic [$clog2(ROWS)-1:0]  rdRow,
   output logic      [WIDTH-1:0]         rdWord
);

   logic [WIDTH-1:0] mem [ROWS];

   // Only the lanes of the addressed word change; neighbours in the row keep their bits.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < ROWS; i++) begin
            mem[i] <= '0;
         end
      end else if (wrEn) begin
         mem[wrRow] <= (mem[wrRow] & ~wrMask) | (wrData & wrMask);
      end
   end

   assign rdWord = mem[rdRow];

endmodule // cemb_storage

/* File: testbench/cemb_line_model.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// Neighbour blocks on the shared output line
// ------------------------------------------------------------
// The three other blocks own every page that this block does not. A line that nobody
// drives shows the inverse of its last level, because nothing holds it there.
module cemb_line_model
   import cemb_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   rdStep,
   input  wire logic [CEMB_PAGE_W-1:0] rdPage,
   input  wire logic [CEMB_PAGE_W-1:0] ownPage,
   input  wire logic                   dutOe,
   input  wire logic [CEMB_DATA_W-1:0] dutLine,
   output logic      [CEMB_DATA_W-1:0] lineLevel,
   output logic      [1:0]             driverCount
);
   logic [CEMB_PAGE_W-1:0] page_r;
   logic [CEMB_DATA_W-1:0] last_r;
   logic                   nbrOe;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         page_r <= 2'h0;
      end else if (rdStep) begin
         page_r <= rdPage;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         last_r <= 16'h0000;
      end else begin
         last_r <= lineLevel;
      end
   end

   assign nbrOe       = (page_r != ownPage);
   assign driverCount = {1'b0, dutOe} + {1'b0, nbrOe};
   assign lineLevel   = dutOe ? dutLine : (nbrOe ? {14'h2AAA, page_r} : ~last_r);
endmodule // cemb_line_model

/* File: testbench/configurable_embedded_memory_block_test.sv */
`timescale 1ns/1ns
module configurable_embedded_memory_block_test;
   import cemb_pkg::*;
   typedef struct {
      cemb_width_t wc;
      logic [10:0] wa;
      logic [15:0] wd;
      cemb_width_t rc;
      logic [10:0] ra;
      logic [15:0] ex;
   } cemb_row_t;
   logic clk, rst_n, ce, outRegEn, wrClkEn, wrClear_n, rdClkEn, rdClear_n;
   logic pageEn, ptClkEn, ptClear_n, lineOe;
   cemb_mode_t                     mode;
   cemb_width_t                    widthCfg;
   cemb_wr_t                       wrPort;
   cemb_rd_t                       rdPort;
   logic [1:0]                     pageSel, driverCount;
   logic [31:0]                    ptIn;
   cemb_mc_cfg_t [CEMB_MC_NUM-1:0] mcCfg;
   logic [15:0]                    dataOut, lineOut, lineLevel, ptWant;
   int                             n_fail, cmp_count;
   cemb_row_t rows [7] = '{
      '{CEMB_W16, 11'h005, 16'hA5C3, CEMB_W16, 11'h005, 16'hA5C3},
      '{CEMB_W8,  11'h00C, 16'h12AB, CEMB_W8,  11'h00C, 16'h00AB},
      '{CEMB_W4,  11'h064, 16'hFFF9, CEMB_W4,  11'h064, 16'h0009},
      '{CEMB_W2,  11'h2BC, 16'h0002, CEMB_W2,  11'h2BC, 16'h0002},
      '{CEMB_W1,  11'h7FF, 16'h0001, CEMB_W1,  11'h7FF, 16'h0001},
      '{CEMB_W16, 11'h000, 16'h1234, CEMB_W4,  11'h001, 16'h0003},
      '{CEMB_W16, 11'h000, 16'h1234, CEMB_W1,  11'h004, 16'h0001}};

   cemb_memory_block dut (.clk(clk), .rst_n(rst_n), .ce(ce), .mode(mode),
      .widthCfg(widthCfg), .outRegEn(outRegEn), .wrClkEn(wrClkEn), .wrClear_n(wrClear_n),
      .wrPort(wrPort), .rdClkEn(rdClkEn), .rdClear_n(rdClear_n), .rdPort(rdPort),
      .pageEn(pageEn), .pageSel(pageSel), .ptClkEn(ptClkEn), .ptClear_n(ptClear_n),
      .ptIn(ptIn), .mcCfg(mcCfg), .dataOut(dataOut), .lineOut(lineOut), .lineOe(lineOe));

   cemb_line_model lineModel (.clk(clk), .rst_n(rst_n), .rdStep(rdClkEn & rdClear_n),
      .rdPage(rdPort.addr[CEMB_PAGE_HI:CEMB_PAGE_LO]), .ownPage(pageSel), .dutOe(lineOe),
      .dutLine(lineOut), .lineLevel(lineLevel), .driverCount(driverCount));

   // ------------------------------------------------------------
   // Clock and watchdog
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // The whole sequence needs well under a thousand cycles.
   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      stop_test();
   end

   // ------------------------------------------------------------
   // Checks and bus cycles
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      cmp_count++;
      if (seen !== want) begin
         n_fail++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic stop_test();
      if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic wr(input cemb_width_t c, input logic [10:0] a, input logic [15:0] d);
      @(posedge clk);
      widthCfg <= c;
      wrPort   <= {a, d, 1'b1};
      wrClkEn  <= 1'b1;
      @(posedge clk);
      wrClkEn   <= 1'b0;
      wrPort.we <= 1'b0;
   endtask

   task automatic rd(input cemb_width_t c, input logic [12:0] a);
      @(posedge clk);
      widthCfg <= c;
      rdPort   <= {a, 1'b1};
      rdClkEn  <= 1'b1;
      @(posedge clk);
      rdClkEn   <= 1'b0;
      rdPort.re <= 1'b0;
      #1;
   endtask

   // ------------------------------------------------------------
   // Stimulus
   // ------------------------------------------------------------
   initial begin
      rst_n = 1'b0; ce = 1'b1; mode = CEMB_MEM_MODE; widthCfg = CEMB_W16;
      outRegEn = 1'b0; wrClkEn = 1'b0; wrClear_n = 1'b1; wrPort = '0;
      rdClkEn = 1'b0; rdClear_n = 1'b1; rdPort = '0; pageEn = 1'b0; pageSel = 2'h2;
      ptClkEn = 1'b0; ptClear_n = 1'b1; ptIn = '0; mcCfg = '0; n_fail = 0; cmp_count = 0;
      repeat (5) @(posedge clk);
      #1 check(dataOut, 16'h0000);
      check({15'h0000, lineOe}, 16'h0000);
      @(posedge clk);
      rst_n <= 1'b1;
      // Upper address bits are set to show that they never reach the array.
      foreach (rows[i]) begin
         wr(rows[i].wc, rows[i].wa, rows[i].wd);
         rd(rows[i].rc, {2'h3, rows[i].ra});
         check(dataOut, rows[i].ex);
         check(lineOut, rows[i].ex);
         check({15'h0000, lineOe}, 16'h0001);
      end
      @(posedge clk);
      widthCfg <= CEMB_W16;
      wrPort   <= {11'h005, 16'h5A3C, 1'b1};
      wrClkEn  <= 1'b1;
      rdPort   <= {13'h0005, 1'b1};
      rdClkEn  <= 1'b1;
      @(posedge clk);
      wrClkEn   <= 1'b0;
      wrPort.we <= 1'b0;
      rdClkEn   <= 1'b0;
      #1 check(dataOut, 16'hA5C3);
      @(posedge clk);
      #1 check(dataOut, 16'h5A3C);
      @(posedge clk);
      outRegEn <= 1'b1;
      rdPort   <= {13'h0005, 1'b1};
      rdClkEn  <= 1'b1;
      @(posedge clk);
      rdPort <= {13'h0000, 1'b1};
      @(posedge clk);
      #1 check(dataOut, 16'h5A3C);
      @(posedge clk);
      rdClkEn <= 1'b0;
      rdPort  <= {13'h0064, 1'b1};
      #1 check(dataOut, 16'h1234);
      repeat (2) @(posedge clk);
      #1 check(dataOut, 16'h1234);
      @(posedge clk);
      rdClear_n <= 1'b0;
      @(posedge clk);
      rdClear_n <= 1'b1;
      #1 check(dataOut, 16'h0000);
      @(posedge clk);
      outRegEn <= 1'b0;
      pageEn   <= 1'b1;
      for (int p = 0; p < 4; p++) begin
         rd(CEMB_W16, {p[1:0], 11'h000});
         check({15'h0000, lineOe}, {15'h0000, p == 2});
         check({14'h0000, driverCount}, 16'h0001);
         check(lineLevel, (p == 2) ? 16'h1234 : {14'h2AAA, p[1:0]});
      end
      @(posedge clk);
      pageEn  <= 1'b0;
      mode    <= CEMB_PTERM_MODE;
      ptClkEn <= 1'b1;
      mcCfg[0].use0 <= 41'h1;
      mcCfg[0].use1 <= 41'h2;
      mcCfg[1].use0 <= 41'h4;
      mcCfg[1].use1 <= 41'h4;
      mcCfg[1].cpl1 <= 41'h4;
      mcCfg[1].inv0 <= 1'b1;
      mcCfg[2].use0 <= 41'h8;
      mcCfg[2].exp0 <= 1'b1;
      mcCfg[2].use1 <= 41'h10;
      mcCfg[3].use0 <= 41'h20;
      mcCfg[3].use1 <= 41'h20;
      mcCfg[4].use0 <= 41'h40;
      mcCfg[4].use1 <= 41'h40;
      mcCfg[4].regOut <= 1'b1;
      mcCfg[5].use0 <= 41'h1000000000;
      mcCfg[5].use1 <= 41'h1000000000;
      mcCfg[6].use0 <= 41'h1;
      mcCfg[6].cpl0 <= 41'h1;
      mcCfg[6].use1 <= 41'h2;
      mcCfg[6].exp1 <= 1'b1;
      mcCfg[6].xorPol <= 1'b1;
      for (int v = 0; v < 128; v++) begin
         @(posedge clk);
         ptIn <= {25'h0000000, v[6:0]};
         @(posedge clk);
         ptWant = {9'h000, v[0], v[6], v[6], v[5] | v[3], v[4], ~v[2], v[1] | v[0]};
         #1 check(dataOut & 16'h000F, ptWant & 16'h000F);
         check(dataOut & 16'h0070, ptWant & 16'h0070);
      end
      @(posedge clk);
      ptClkEn  <= 1'b0;
      ptIn[6]  <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check({15'h0000, dataOut[4]}, 16'h0001);
      @(posedge clk);
      ptClear_n <= 1'b0;
      @(posedge clk);
      ptClear_n <= 1'b1;
      #1 check({15'h0000, dataOut[4]}, 16'h0000);
      @(posedge clk);
      mode  <= CEMB_MEM_MODE;
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      rd(CEMB_W16, 13'h0005);
      check(dataOut, 16'h0000);
      // A low clock enable holds the write back, and a write side clear then drops it.
      @(posedge clk);
      ce      <= 1'b0;
      wrPort  <= {11'h005, 16'h5AA5, 1'b1};
      wrClkEn <= 1'b1;
      repeat (2) @(posedge clk);
      ce        <= 1'b1;
      wrClear_n <= 1'b0;
      @(posedge clk);
      wrClear_n <= 1'b1;
      wrClkEn   <= 1'b0;
      wrPort.we <= 1'b0;
      repeat (2) @(posedge clk);
      rd(CEMB_W16, 13'h0005);
      check(dataOut, 16'h0000);
      stop_test();
   end
endmodule // configurable_embedded_memory_block_test
